// File: ccs_clock_ctl.sv
// CPU clock source select, prescaler and STOP-release stabilization wait
// ********************************************
// How it works
// - Counter stops at the selected limit
// - Wait counts only after oscillation starts
// - Internal oscillator drives prescaler when selected
// - Stop control works only if option allows
// - Divider change returning to high-speed accepted
// ********************************************
`timescale 1ns/1ps
module ccs_clock_ctl
	import ccs_pkg::*;
#(
	parameter int STCNT_W = 5,
	parameter int BASE_TICKS = 256 // Base stabilization time, system clock cycles
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        opt_iosc_stoppable,
	input  wire logic        stop_release,
	output logic             cpu_clk_en,
	output logic             iosc_running,
	output logic             in_stop
);

	// ********************************************
	// Registers
	// ********************************************
	ccs_clksel_t clksel_reg, clksel_next;
	logic [2:0] stsel_reg, stsel_next;
	logic [STCNT_W-1:0] stcnt_reg, stcnt_next;
	logic stopc_reg, stopc_next;
	ccs_state_t state_reg, state_next;
	logic [15:0] base_reg, base_next;
	logic [3:0] start_reg, start_next;
	logic [7:0] osc_reg, osc_next;
	logic [CCS_PRE_W-1:0] pre_reg, pre_next;
	logic cpu_en_reg, cpu_en_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	logic wr, rd_ok, osc_tick, div_tick;
	logic [2:0] lim;
	logic [STCNT_W-1:0] lim_mask;

	assign wr = psel && penable && pwrite && !pready_reg;
	assign lim = (stsel_reg > CCS_STSEL_MAX) ? CCS_STSEL_MAX : stsel_reg;
	// Status mask reaching only the selected limit
	assign lim_mask = STCNT_W'((1 << (32'(lim) + 1)) - 1);
	assign rd_ok = (paddr == CCS_CLKSEL_OFF) || (paddr == CCS_STSEL_OFF) ||
		(paddr == CCS_STCNT_OFF) || (paddr == CCS_OSC_OFF) ||
		(paddr == CCS_STOP_OFF);

	// Internal oscillator tick (stopped if stop control honoured)
	assign osc_tick = (osc_reg == 8'(CCS_IOSC_DIV - 1)) && !stopc_reg;

	// Prescaler tap chosen by divider; internal osc clock feeds it when selected
	always_comb begin
		logic [CCS_PRE_W-1:0] mask;
		mask = '1;
		if (32'(clksel_reg.div) < CCS_PRE_W)
			mask = CCS_PRE_W'((1 << clksel_reg.div) - 1);
		div_tick = (pre_reg & mask) == mask;
	end

	// ********************************************
	// Clock generation next state
	// ********************************************
	always_comb begin
		osc_next = osc_reg;
		pre_next = pre_reg;
		cpu_en_next = 1'b0;
		if (state_reg == CCS_RUN) begin
			if (osc_reg == 8'(CCS_IOSC_DIV - 1))
				osc_next = '0;
			else
				osc_next = osc_reg + 8'h01;
		end
		// Source base tick: internal osc or system clock
		if (clksel_reg.iosc) begin
			if (osc_tick) begin
				pre_next = pre_reg + CCS_PRE_W'(1);
				cpu_en_next = div_tick && state_reg == CCS_RUN;
			end
		end else begin
			pre_next = pre_reg + CCS_PRE_W'(1);
			cpu_en_next = div_tick && state_reg == CCS_RUN;
		end
	end

	// ********************************************
	// Software registers and STOP sequencer next state
	// ********************************************
	always_comb begin
		clksel_next = clksel_reg;
		stsel_next = stsel_reg;
		stopc_next = stopc_reg;
		state_next = state_reg;
		stcnt_next = stcnt_reg;
		base_next = base_reg;
		start_next = start_reg;
		if (wr && paddr == CCS_CLKSEL_OFF) begin
			// Source and divider taken together in one write
			clksel_next.div = pwdata[CCS_DIV_LSB +: 3];
			clksel_next.src = pwdata[CCS_SRC_BIT];
			clksel_next.iosc = pwdata[CCS_IOSC_BIT];
		end
		if (wr && paddr == CCS_STSEL_OFF)
			stsel_next = pwdata[2:0];
		if (wr && paddr == CCS_OSC_OFF && opt_iosc_stoppable)
			stopc_next = pwdata[CCS_STOPC_BIT];
		if (!opt_iosc_stoppable)
			stopc_next = 1'b0;
		case (state_reg)
			CCS_RUN: begin
				if (wr && paddr == CCS_STOP_OFF && pwdata[0]) begin
					state_next = CCS_STOPPED;
					stcnt_next = '0;
				end
			end
			CCS_STOPPED: begin
				if (stop_release) begin
					state_next = CCS_OSC_START;
					start_next = '0;
				end
			end
			CCS_OSC_START: begin
				// Start-up time is not part of the wait
				if (start_reg == 4'(CCS_START_CYC - 1)) begin
					state_next = CCS_WAIT;
					base_next = '0;
				end else
					start_next = start_reg + 4'h1;
			end
			CCS_WAIT: begin
				if (base_reg == 16'(BASE_TICKS - 1)) begin
					base_next = '0;
					if (stcnt_reg == lim_mask)
						state_next = CCS_RUN;
					else
						stcnt_next = (stcnt_reg << 1 | STCNT_W'(1)) &
							lim_mask;
				end else
					base_next = base_reg + 16'h0001;
			end
			default: state_next = CCS_RUN;
		endcase
	end

	// APB answer, one wait state
	always_comb begin
		pready_next = psel && penable && !pready_reg;
		pslverr_next = pready_next && !rd_ok;
		prdata_next = '0;
		if (psel && penable && !pwrite && !pready_reg) begin
			case (paddr)
				CCS_CLKSEL_OFF: prdata_next = 32'({clksel_reg.iosc,
					clksel_reg.src, 1'b0, clksel_reg.div});
				CCS_STSEL_OFF: prdata_next = 32'(stsel_reg);
				CCS_STCNT_OFF: prdata_next = 32'(stcnt_reg);
				CCS_OSC_OFF: prdata_next = 32'(stopc_reg) |
					(32'(state_reg != CCS_RUN) << CCS_STOPM_BIT) |
					(32'(state_reg == CCS_WAIT) << CCS_WAIT_BIT);
				default: prdata_next = '0;
			endcase
		end
	end

	// ********************************************
	// State registers
	// ********************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clksel_reg <= '{iosc: CCS_IOSC_RST, src: 1'b0,
				div: CCS_DIV_RST};
			stsel_reg <= CCS_STSEL_RST;
			stcnt_reg <= '0;
			stopc_reg <= 1'b0;
			state_reg <= CCS_RUN;
			base_reg <= '0;
			start_reg <= '0;
			osc_reg <= '0;
			pre_reg <= '0;
			cpu_en_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			clksel_reg <= clksel_next;
			stsel_reg <= stsel_next;
			stcnt_reg <= stcnt_next;
			stopc_reg <= stopc_next;
			state_reg <= state_next;
			base_reg <= base_next;
			start_reg <= start_next;
			osc_reg <= osc_next;
			pre_reg <= pre_next;
			cpu_en_reg <= cpu_en_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	logic iosc_run_reg, in_stop_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iosc_run_reg <= 1'b1;
			in_stop_reg <= 1'b0;
		end else begin
			iosc_run_reg <= !stopc_next;
			in_stop_reg <= state_next != CCS_RUN;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign cpu_clk_en = cpu_en_reg;
	assign iosc_running = iosc_run_reg;
	assign in_stop = in_stop_reg;

	// ********************************************
	// Assertions
	// ********************************************
	sequence release_s;
		state_reg == CCS_STOPPED && stop_release;
	endsequence

	sequence start_s;
		state_reg == CCS_OSC_START [*8];
	endsequence

	stat_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(stcnt_reg & ~lim_mask) == '0 || state_reg != CCS_WAIT)
		else $error("status counter beyond selected limit");

	start_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		release_s |=> start_s ##1 (state_reg == CCS_WAIT && base_reg == '0))
		else $error("wait began before oscillation start");

	stop_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!opt_iosc_stoppable |=> !stopc_reg)
		else $error("stop control honoured without option");

	div_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == CCS_CLKSEL_OFF |=>
		clksel_reg.div == $past(pwdata[2:0]) &&
		clksel_reg.src == $past(pwdata[CCS_SRC_BIT]))
		else $error("combined divider and source write lost");

	iosc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clksel_reg.iosc && !$past(osc_tick) && $past(clksel_reg.iosc) |->
		!cpu_clk_en)
		else $error("cpu enable without oscillator tick");

	stop_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == CCS_STOPPED ##1 state_reg == CCS_STOPPED |-> !cpu_clk_en)
		else $error("cpu clock ran during stop");

	// Bus answer lasts one cycle and an error only comes with it
	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	err_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without ready");

	unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && !rd_ok |=> $stable(clksel_reg) && $stable(stsel_reg))
		else $error("write to unmapped address took effect");

	// No CPU clock while stopped, starting up or waiting
	wait_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		in_stop |=> !cpu_clk_en)
		else $error("cpu clock ran during stop or wait");

	stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == CCS_RUN && wr && paddr == CCS_STOP_OFF && pwdata[0] |=>
		stcnt_reg == '0 && in_stop)
		else $error("status not cleared on stop entry");

	stat_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == CCS_WAIT && base_reg != 16'(BASE_TICKS - 1) |=>
		$stable(stcnt_reg))
		else $error("status stepped off the base tick");

	// Stopped internal oscillator gives no CPU clock
	osc_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		stopc_reg && clksel_reg.iosc |=> !cpu_clk_en)
		else $error("cpu clock from stopped oscillator");

	osc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		iosc_running == !stopc_reg)
		else $error("running flag disagrees with stop control");

endmodule

// File: ccs_pkg.sv
// Package: register map, field layout, reset values and timing for clock control
package ccs_pkg;

	// ********************************************
	// Register byte offsets
	// ********************************************
	localparam logic [7:0] CCS_CLKSEL_OFF = 8'h00; // Source select and divider
	localparam logic [7:0] CCS_STSEL_OFF  = 8'h04; // Stabilization time select
	localparam logic [7:0] CCS_STCNT_OFF  = 8'h08; // Stabilization status (RO)
	localparam logic [7:0] CCS_OSC_OFF    = 8'h0C; // Oscillator control/status
	localparam logic [7:0] CCS_STOP_OFF   = 8'h10; // STOP entry, write 1

	// ********************************************
	// Field positions
	// ********************************************
	localparam int CCS_DIV_LSB  = 0; // cpu_div_bit2..0 at [2:0]
	localparam int CCS_SRC_BIT  = 4; // cpu_src_subsys_sel
	localparam int CCS_IOSC_BIT = 5; // Internal oscillator as CPU clock
	localparam int CCS_STOPC_BIT = 0; // int_osc_stop_ctl in OSC register
	localparam int CCS_STOPM_BIT = 8; // In STOP, read only
	localparam int CCS_WAIT_BIT = 9; // Stabilization wait running, read only

	// ********************************************
	// Reset values and limits
	// ********************************************
	localparam logic [2:0] CCS_DIV_RST   = 3'h0;
	localparam logic       CCS_IOSC_RST  = 1'b1; // Internal osc drives CPU
	localparam logic [2:0] CCS_STSEL_RST = 3'h5;
	localparam logic [2:0] CCS_STSEL_MAX = 3'h4; // Codes above this clamp
	localparam int         CCS_PRE_W     = 5;    // Prescaler taps /1../32

	// Internal oscillator nominal rate, kHz
	localparam int CCS_IOSC_KHZ = 240;
	localparam int CCS_PCLK_KHZ = 40000;
	// System clocks per internal oscillator tick (rounded down, at least 1)
	localparam int CCS_IOSC_DIV = (CCS_PCLK_KHZ / CCS_IOSC_KHZ) < 1 ? 1 :
		(CCS_PCLK_KHZ / CCS_IOSC_KHZ);

	// Cycles from STOP release until oscillation starts (oscillator start-up)
	localparam int CCS_START_CYC = 8;

	// ********************************************
	// Types
	// ********************************************
	typedef enum logic [1:0] {
		CCS_RUN,
		CCS_STOPPED,
		CCS_OSC_START,
		CCS_WAIT
	} ccs_state_t;

	typedef struct packed {
		logic       iosc;
		logic       src;
		logic [2:0] div;
	} ccs_clksel_t;

endpackage

// File: ccs_clock_ctl_test.sv
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
module ccs_clock_ctl_test;
	import ccs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, v;
	logic        pready, pslverr, opt_iosc_stoppable, stop_release, e;
	logic        cpu_clk_en, iosc_running, in_stop;
	int          n_fail, samples_checked;

	ccs_clock_ctl #(.BASE_TICKS(4)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .opt_iosc_stoppable(opt_iosc_stoppable),
		.stop_release(stop_release), .cpu_clk_en(cpu_clk_en),
		.iosc_running(iosc_running), .in_stop(in_stop));

	// ********************************************
	// Shared tasks
	// ********************************************
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] s);
		samples_checked++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ********************************************
	// Scenarios
	// ********************************************
	// Reset values of select registers
	task automatic t_reset;
		apb(0, CCS_CLKSEL_OFF, 0);
		chk("clksel", 32'h0000_0020, v);
		apb(0, CCS_STSEL_OFF, 0);
		chk("stsel", 32'h0000_0005, v);
		chk("iosc_running", 32'h0000_0001, {31'h0, iosc_running});
	endtask

	// Stop control honoured only when the option allows
	task automatic t_stop_ctl;
		apb(1, CCS_OSC_OFF, 32'h0000_0001);
		apb(0, CCS_OSC_OFF, 0);
		chk("stop ctl locked", 32'h0000_0000, v & 32'h1);
		chk("osc locked", 32'h0000_0001, {31'h0, iosc_running});
		opt_iosc_stoppable <= 1'b1;
		apb(1, CCS_OSC_OFF, 32'h0000_0001);
		apb(0, CCS_OSC_OFF, 0);
		chk("stop ctl", 32'h0000_0001, v & 32'h1);
		chk("osc stopped", 32'h0000_0000, {31'h0, iosc_running});
		apb(1, CCS_OSC_OFF, 32'h0000_0000);
		chk("osc restart", 32'h0000_0001, {31'h0, iosc_running});
	endtask

	// Source to subsystem alone, then back with a new divider at once
	task automatic t_src_return;
		apb(1, CCS_CLKSEL_OFF, 32'h0000_0010);
		apb(0, CCS_CLKSEL_OFF, 0);
		chk("to subsystem", 32'h0000_0010, v);
		apb(1, CCS_CLKSEL_OFF, 32'h0000_0003);
		apb(0, CCS_CLKSEL_OFF, 0);
		chk("back with div", 32'h0000_0003, v);
		apb(1, CCS_CLKSEL_OFF, 32'h0000_0020);
	endtask

	// STOP, release, start-up gap, then status filled to the limit
	task automatic t_stab(input logic [2:0] sel, input logic [31:0] m);
		apb(0, CCS_STCNT_OFF, 0);
		apb(1, CCS_STSEL_OFF, {29'h0, sel});
		apb(1, CCS_STOP_OFF, 32'h0000_0001);
		chk("in stop", 32'h0000_0001, {31'h0, in_stop});
		stop_release <= 1'b1;
		@(posedge pclk);
		stop_release <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(0, CCS_STCNT_OFF, 0);
		chk("status in start-up", 32'h0000_0000, v);
		apb(0, CCS_OSC_OFF, 0);
		chk("stopped in start-up", 32'h0000_0100, v);
		apb(0, CCS_OSC_OFF, 0);
		chk("waiting after start-up", 32'h0000_0300, v);
		repeat (120) @(posedge pclk);
		apb(0, CCS_STCNT_OFF, 0);
		chk("status limit", m, v);
		chk("stop left", 32'h0000_0000, {31'h0, in_stop});
	endtask

	// CPU clock enables spaced by internal oscillator ticks and divider
	task automatic t_prescale(input logic [2:0] d);
		int g;
		int k;
		g = 0;
		k = 0;
		apb(1, CCS_CLKSEL_OFF, 32'h0000_0020 | 32'(d));
		while (cpu_clk_en !== 1'b1 && k < 4000) begin
			@(posedge pclk);
			k++;
		end
		do begin
			@(posedge pclk);
			g++;
		end while (cpu_clk_en !== 1'b1 && g < 4000);
		chk("pulse gap", CCS_IOSC_DIV << d, g);
	endtask

	// Reset input in the middle of STOP leaves it and restores defaults
	task automatic t_midrst;
		apb(1, CCS_STOP_OFF, 32'h0000_0001);
		chk("stop before reset", 32'h0000_0001, {31'h0, in_stop});
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("stop left by reset", 32'h0000_0000, {31'h0, in_stop});
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, CCS_CLKSEL_OFF, 0);
		chk("clksel after reset", 32'h0000_0020, v);
		apb(0, CCS_STCNT_OFF, 0);
		chk("status after reset", 32'h0000_0000, v);
	endtask

	// Unmapped address is refused and a write there changes nothing
	task automatic t_unmapped;
		apb(0, 8'h14, 0);
		chk("unmapped err", 32'h0000_0001, {31'h0, e});
		apb(1, 8'h14, 32'h0000_0003);
		chk("unmapped write err", 32'h0000_0001, {31'h0, e});
		apb(0, CCS_STSEL_OFF, 0);
		chk("select kept", 32'h0000_0005, v);
	endtask

	// ********************************************
	// Clock, reset, sequence and watchdog
	// ********************************************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, stop_release, opt_iosc_stoppable} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_stop_ctl();
		t_src_return();
		t_stab(3'h0, 32'h0000_0001);
		t_stab(3'h2, 32'h0000_0007);
		t_stab(3'h7, 32'h0000_001F);
		t_prescale(3'h0);
		t_prescale(3'h1);
		t_midrst();
		t_unmapped();
		tally_and_finish();
	end
endmodule
